// ===== shared/tcoc_cfg.svh
// Register map, field positions, codes and reset values of the compare-output block
`ifndef TCOC_CFG_SVH
`define TCOC_CFG_SVH

// ----------------------------------------------------------------
// Word indices on the bus (byte address = index * 4)
// ----------------------------------------------------------------
`define TCOC_IDX_T1_CTRL_A 3'h0
`define TCOC_IDX_T1_CTRL_B 3'h1
`define TCOC_IDX_T3_CTRL_A 3'h2
`define TCOC_IDX_T3_CTRL_B 3'h3
`define TCOC_IDX_STATUS    3'h4
`define TCOC_ADR_HI_ZERO   3'h0

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TCOC_ACT_A_LO      6
`define TCOC_ACT_B_LO      4
`define TCOC_ACT_C_LO      2
`define TCOC_WGML_LO       0
`define TCOC_WGMH_LO       3
`define TCOC_STAT_T3_LO    4
`define TCOC_CTRL_RST      8'h00
`define TCOC_WGMH_RST      2'h0
`define TCOC_MODE_RST      4'h0
`define TCOC_WORD_ZERO     32'h0000_0000

// ----------------------------------------------------------------
// Action codes and mode values
// ----------------------------------------------------------------
`define TCOC_ACT_OFF       2'h0
`define TCOC_ACT_TOG       2'h1
`define TCOC_ACT_CLR       2'h2
`define TCOC_ACT_SET       2'h3
`define TCOC_WGM_FAST_OCA  4'hF
`define TCOC_WGM_PFC_OCA   4'h9
`define TCOC_WGM_PC_OCA    4'hB

`endif

// ===== shared/tcoc_pkg.sv
// Types shared by the compare-output control block
`default_nettype none

package tcoc_pkg;

    // Mode class of the waveform mode
    typedef enum logic [1:0] {
        CLS_NONPWM = 2'b00,
        CLS_FAST   = 2'b01,
        CLS_DUAL   = 2'b10
    } tcoc_class_e;

    // Bus slave state
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } tcoc_bus_e;

    // Counter events of one timer, index 0 = channel A
    typedef struct packed {
        logic [2:0] match;
        logic [2:0] eq_top;
        logic [2:0] eq_bottom;
        logic       bottom;
        logic       up;
    } tcoc_cnt_s;

    // Pin side of one timer
    typedef struct packed {
        logic [2:0] wave;
        logic [2:0] ovr;
        logic [2:0] oe;
    } tcoc_pins_s;

endpackage : tcoc_pkg

`default_nettype wire

// ===== verilog/tcoc_chan.sv
// One compare-output channel: action decode, waveform flop and pin override
`include "tcoc_cfg.svh"
`default_nettype none

module tcoc_chan (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Setup
    input  wire logic [1:0] act_i,
    input  wire logic [3:0] mode_i,
    input  wire logic       is_a_i,
    input  wire logic       dir_out_i,
    // Counter events
    input  wire logic       match_i,
    input  wire logic       bottom_i,
    input  wire logic       up_i,
    input  wire logic       eq_top_i,
    input  wire logic       eq_bottom_i,
    // Pin side
    output logic            wave_o,
    output logic            ovr_o,
    output logic            oe_o
);

    function automatic tcoc_pkg::tcoc_class_e class_of(input logic [3:0] m);
        case (m)
            4'h0, 4'h4, 4'hC, 4'hD: class_of = tcoc_pkg::CLS_NONPWM;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = tcoc_pkg::CLS_FAST;
            default: class_of = tcoc_pkg::CLS_DUAL;
        endcase
    endfunction : class_of

    tcoc_pkg::tcoc_class_e cls;
    logic tog_ok, conn, tog;
    logic wave_nxt, ovr_nxt, oe_nxt;

    always_comb begin
        cls = class_of(mode_i); // R4
        case (cls)
            tcoc_pkg::CLS_NONPWM: tog_ok = 1'b1;
            tcoc_pkg::CLS_FAST:   tog_ok = is_a_i && (mode_i == `TCOC_WGM_FAST_OCA); // R7
            default: tog_ok = is_a_i && (mode_i == `TCOC_WGM_PFC_OCA ||
                                         mode_i == `TCOC_WGM_PC_OCA); // R10
        endcase
        conn = (act_i != `TCOC_ACT_OFF) && (act_i != `TCOC_ACT_TOG || tog_ok); // R1 R5
        tog = (act_i == `TCOC_ACT_TOG) && tog_ok && match_i;
        wave_nxt = tog ? !wave_o : wave_o;
        if (act_i[1]) begin
            case (cls)
                tcoc_pkg::CLS_NONPWM: begin
                    if (match_i) wave_nxt = act_i[0]; // R6
                end
                tcoc_pkg::CLS_FAST: begin
                    if (bottom_i) wave_nxt = !act_i[0]; // R8
                    if (match_i && !eq_top_i) wave_nxt = act_i[0]; // R8 R9
                end
                default: begin
                    if (eq_bottom_i) wave_nxt = act_i[0]; // R12
                    else if (eq_top_i) wave_nxt = !act_i[0]; // R12
                    else if (match_i) wave_nxt = up_i ? act_i[0] : !act_i[0]; // R11
                end
            endcase
        end
        ovr_nxt = conn;
        oe_nxt = conn && dir_out_i; // R3
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_o <= 1'b0;
            ovr_o  <= 1'b0;
            oe_o   <= 1'b0;
        end else begin
            wave_o <= wave_nxt;
            ovr_o  <= ovr_nxt;
            oe_o   <= oe_nxt;
        end
    end

    chk_oe_needs_dir: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        !dir_out_i |=> !oe_o) else $error("driver on without output direction");
    chk_off_disconn: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        act_i == `TCOC_ACT_OFF |=> !ovr_o && !oe_o) else $error("off field still connected");
    chk_fast_top_ign: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        cls == tcoc_pkg::CLS_FAST && act_i[1] && match_i && eq_top_i && !bottom_i
        |=> wave_o == $past(wave_o)) else $error("match at top not ignored");
    chk_dual_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        cls == tcoc_pkg::CLS_DUAL && act_i == `TCOC_ACT_CLR && eq_bottom_i [*2]
        |=> !wave_o) else $error("bottom compare not held low");
    chk_nonpwm_tog: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        cls == tcoc_pkg::CLS_NONPWM && act_i == `TCOC_ACT_TOG && match_i
        |=> wave_o != $past(wave_o)) else $error("toggle on match missing");

endmodule : tcoc_chan

`default_nettype wire

// ===== verilog/tcoc_top.sv
// Compare-output control for timers 1 and 3, with a classic Wishbone register slave
//
// What this block does
// R1: A nonzero action field routes that channel's waveform to its pin, except an 01 that R7 or R10 leaves disconnected.
// R2: Channel B action sits at bits 5:4, channel C at bits 3:2.
// R3: The pin is driven only when its direction bit selects output.
// R4: Each action field is read by the current mode class.
// R5: Field 00 leaves the channel disconnected in every mode.
// R6: Non-PWM: 01 toggles, 10 clears, 11 sets on compare match.
// R7: Fast PWM 01 toggles channel A only in mode 15; others disconnected.
// R8: Fast PWM 10 clears on match, sets at bottom; 11 the reverse.
// R9: Fast PWM compare equal to top ignores match, keeps bottom action.
// R10: Dual-slope 01 toggles channel A only in modes 9 or 11.
// R11: Dual-slope 10 clears on up-count match, sets on down-count; 11 reverse.
// R12: Dual-slope compare at bottom holds low, at top high; inverted opposite.
// R13: Mode is two low bits of control A plus two bits of control B.
// R14: Both control A registers read zero after reset.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`include "tcoc_cfg.svh"
`default_nettype none

module tcoc_top (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Counter events, index 0 = timer 1, index 1 = timer 3
    input  wire tcoc_pkg::tcoc_cnt_s  [1:0]    cnt_i,
    // Port direction bits of the three compare pins of each timer
    input  wire logic [1:0][2:0]               dir_out_i,
    // Compare pins
    output tcoc_pkg::tcoc_pins_s [1:0]         pins_o,
    // Waveform mode to the counters
    output logic [1:0][3:0]                    waveform_mode_sel_o
);

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------

    // Only the low five words, indices 0 to 4, are decoded
    function automatic logic is_mapped(input logic [7:0] adr);
        is_mapped = (adr[7:5] == `TCOC_ADR_HI_ZERO) && (adr[4:2] <= `TCOC_IDX_STATUS);
    endfunction : is_mapped

    function automatic logic [1:0] act_field(input logic [7:0] ctrl, input logic [1:0] ch);
        case (ch)
            2'h0:    act_field = ctrl[`TCOC_ACT_A_LO +: 2];
            2'h1:    act_field = ctrl[`TCOC_ACT_B_LO +: 2]; // R2
            default: act_field = ctrl[`TCOC_ACT_C_LO +: 2]; // R2
        endcase
    endfunction : act_field

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------

    tcoc_pkg::tcoc_bus_e bus_st_r;
    tcoc_pkg::tcoc_bus_e bus_st_nxt;
    logic [1:0][7:0]     ctrl_a_r;
    logic [1:0][7:0]     ctrl_a_nxt;
    logic [1:0][1:0]     wgm_hi_r;
    logic [1:0][1:0]     wgm_hi_nxt;
    logic [1:0][3:0]     mode_nxt;
    logic [31:0]         dat_nxt;
    logic                req;
    logic                wr_lane0;
    logic [2:0]          idx;
    logic [7:0]          status;

    always_comb begin
        req = wb_cyc_i && wb_stb_i && (bus_st_r == tcoc_pkg::BUS_IDLE);
        wr_lane0 = req && wb_we_i && wb_sel_i[0] && is_mapped(wb_adr_i);
        idx = wb_adr_i[4:2];
        ctrl_a_nxt = ctrl_a_r;
        wgm_hi_nxt = wgm_hi_r;
        dat_nxt = `TCOC_WORD_ZERO;
        status = {1'b0, pins_o[1].wave, 1'b0, pins_o[0].wave};
        case (bus_st_r)
            tcoc_pkg::BUS_IDLE: bus_st_nxt = req ? tcoc_pkg::BUS_ACK : tcoc_pkg::BUS_IDLE;
            tcoc_pkg::BUS_ACK:  bus_st_nxt = tcoc_pkg::BUS_IDLE;
            default:            bus_st_nxt = tcoc_pkg::BUS_IDLE;
        endcase
        // Writes land in byte lane 0 only
        if (wr_lane0) begin
            case (idx)
                `TCOC_IDX_T1_CTRL_A: ctrl_a_nxt[0] = wb_dat_i[7:0];
                `TCOC_IDX_T3_CTRL_A: ctrl_a_nxt[1] = wb_dat_i[7:0];
                `TCOC_IDX_T1_CTRL_B: wgm_hi_nxt[0] = wb_dat_i[`TCOC_WGMH_LO +: 2]; // R13
                `TCOC_IDX_T3_CTRL_B: wgm_hi_nxt[1] = wb_dat_i[`TCOC_WGMH_LO +: 2]; // R13
                default: ;
            endcase
        end
        // Unmapped reads answer with zero
        if (req && !wb_we_i && is_mapped(wb_adr_i)) begin
            case (idx)
                `TCOC_IDX_T1_CTRL_A: dat_nxt[7:0] = ctrl_a_r[0];
                `TCOC_IDX_T3_CTRL_A: dat_nxt[7:0] = ctrl_a_r[1];
                `TCOC_IDX_T1_CTRL_B: dat_nxt[`TCOC_WGMH_LO +: 2] = wgm_hi_r[0];
                `TCOC_IDX_T3_CTRL_B: dat_nxt[`TCOC_WGMH_LO +: 2] = wgm_hi_r[1];
                `TCOC_IDX_STATUS:    dat_nxt[7:0] = status;
                default: ;
            endcase
        end
        for (int t = 0; t < 2; t++) begin
            mode_nxt[t] = {wgm_hi_nxt[t], ctrl_a_nxt[t][`TCOC_WGML_LO +: 2]}; // R13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_r <= tcoc_pkg::BUS_IDLE;
            ctrl_a_r <= {2{`TCOC_CTRL_RST}}; // R14
            wgm_hi_r <= {2{`TCOC_WGMH_RST}};
            waveform_mode_sel_o <= {2{`TCOC_MODE_RST}};
            wb_dat_o <= `TCOC_WORD_ZERO;
            wb_ack_o <= 1'b0;
        end else begin
            bus_st_r <= bus_st_nxt;
            ctrl_a_r <= ctrl_a_nxt;
            wgm_hi_r <= wgm_hi_nxt;
            waveform_mode_sel_o <= mode_nxt;
            wb_dat_o <= dat_nxt;
            wb_ack_o <= (bus_st_nxt == tcoc_pkg::BUS_ACK);
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------

    // The mode register lags a write by nothing: mode and action change together
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        for (genvar c = 0; c < 3; c++) begin : g_ch
            tcoc_chan u_chan (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .act_i       (act_field(ctrl_a_r[t], 2'(c))), // R1
                .mode_i      (waveform_mode_sel_o[t]), // R4
                .is_a_i      (c == 0),
                .dir_out_i   (dir_out_i[t][c]),
                .match_i     (cnt_i[t].match[c]),
                .bottom_i    (cnt_i[t].bottom),
                .up_i        (cnt_i[t].up),
                .eq_top_i    (cnt_i[t].eq_top[c]),
                .eq_bottom_i (cnt_i[t].eq_bottom[c]),
                .wave_o      (pins_o[t].wave[c]),
                .ovr_o       (pins_o[t].ovr[c]),
                .oe_o        (pins_o[t].oe[c])
            );
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");

    chk_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        req && wb_we_i && wb_sel_i[0] && wb_adr_i == {3'h0, `TCOC_IDX_T1_CTRL_A, 2'h0}
        |=> ctrl_a_r[0] == $past(wb_dat_i[7:0]))
        else $error("control A write lost");

    chk_chan_b_off: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        ctrl_a_r[0][`TCOC_ACT_B_LO +: 2] == `TCOC_ACT_OFF [*2] |-> !pins_o[0].ovr[1])
        else $error("channel B connected with field zero");

    chk_mode_form: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        req && wb_we_i && wb_sel_i[0] && wb_adr_i == {3'h0, `TCOC_IDX_T3_CTRL_B, 2'h0}
        |=> waveform_mode_sel_o[1][3:2] == $past(wb_dat_i[`TCOC_WGMH_LO +: 2]))
        else $error("mode upper bits not taken");

    chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && !is_mapped(wb_adr_i) |=> wb_ack_o && wb_dat_o == `TCOC_WORD_ZERO)
        else $error("unmapped read not zero");

endmodule : tcoc_top

`default_nettype wire

// ===== tb/test_tcoc_top.sv
// Self-checking bench for the compare-output block: register and pin scenarios
`default_nettype none

module test_tcoc_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                        clk_i;
    logic                        rst_i;
    logic                        cyc;
    logic                        stb;
    logic                        we;
    logic [7:0]                  adr;
    logic [3:0]                  sel;
    logic [31:0]                 wdat;
    logic [31:0]                 rdat;
    logic                        ack;
    tcoc_pkg::tcoc_cnt_s  [1:0]  cnt;
    logic [1:0][2:0]             dir;
    tcoc_pkg::tcoc_pins_s [1:0]  pins;
    logic [1:0][3:0]             mode;
    logic [31:0]                 q;
    int                          bad_count;
    int                          check_count;

    tcoc_top DUT (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_cyc_i            (cyc),
        .wb_stb_i            (stb),
        .wb_we_i             (we),
        .wb_adr_i            (adr),
        .wb_sel_i            (sel),
        .wb_dat_i            (wdat),
        .wb_dat_o            (rdat),
        .wb_ack_o            (ack),
        .cnt_i               (cnt),
        .dir_out_i           (dir),
        .pins_o              (pins),
        .waveform_mode_sel_o (mode)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg

    // Pin bits compared as {wave, ovr, oe}; mask hides a wave of unknown history
    task automatic cmp_pin(input int t, input int c, input logic [2:0] exp,
                           input logic [2:0] msk = 3'h7);
        logic [2:0] got;
        @(negedge clk_i);
        got = {pins[t].wave[c], pins[t].ovr[c], pins[t].oe[c]} & msk;
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pin

    // Master waits on ack with no assumed latency, only a bounded count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hF;
        adr  <= a;
        wdat <= d;
        // Ack and read data are taken at the same rising edge, before it updates them
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            complete_run();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        cmp_reg(q, exp);
    endtask : rd

    // One-cycle counter event on timer t
    task automatic ev(input int t, input logic [2:0] m, input logic bot, input logic up,
                      input logic [2:0] et = 3'h0, input logic [2:0] eb = 3'h0);
        @(posedge clk_i);
        cnt[t] <= {m, et, eb, bot, up};
        @(posedge clk_i);
        cnt[t] <= '0;
        @(posedge clk_i);
    endtask : ev

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        bad_count = 0;
        check_count = 0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        cnt = '0;
        dir = 6'h3F;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        bus(1'b1, 8'h14, 32'h0000_00FF);
        rd(8'h00, 32'h0000_0000);
        cmp_pin(0, 0, 3'h0);
        // Non-PWM actions on channel A
        bus(1'b1, 8'h00, 32'h0000_0040);
        cmp_pin(0, 0, 3'h3);
        cmp_pin(0, 1, 3'h0);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h7);
        dir[0][0] <= 1'b0;
        @(posedge clk_i);
        cmp_pin(0, 0, 3'h6);
        @(posedge clk_i);
        dir[0][0] <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_0080);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h3);
        bus(1'b1, 8'h00, 32'h0000_00C0);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h7);
        // Field placement of channels B and C
        bus(1'b1, 8'h00, 32'h0000_0014);
        rd(8'h00, 32'h0000_0014);
        cmp_pin(0, 0, 3'h4);
        cmp_pin(0, 1, 3'h3);
        cmp_pin(0, 2, 3'h3);
        ev(0, 3'h2, 1'b0, 1'b0);
        cmp_pin(0, 1, 3'h7);
        cmp_pin(0, 2, 3'h3);
        // Fast PWM, modes 15 and 14
        bus(1'b1, 8'h04, 32'h0000_00FF);
        rd(8'h04, 32'h0000_0018);
        bus(1'b1, 8'h00, 32'h0000_0053);
        cmp_reg({28'h0, mode[0]}, 32'h0000_000F);
        cmp_pin(0, 1, 3'h4);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h3);
        bus(1'b1, 8'h00, 32'h0000_0052);
        cmp_pin(0, 0, 3'h0);
        bus(1'b1, 8'h00, 32'h0000_0083);
        ev(0, 3'h0, 1'b1, 1'b0);
        cmp_pin(0, 0, 3'h7);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h1, 1'b0, 1'b0, 3'h1);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h0, 1'b1, 1'b0, 3'h1);
        cmp_pin(0, 0, 3'h7);
        bus(1'b1, 8'h00, 32'h0000_00C3);
        ev(0, 3'h0, 1'b1, 1'b0);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h7);
        // Dual-slope PWM, modes 9 and 11
        bus(1'b1, 8'h04, 32'h0000_0010);
        bus(1'b1, 8'h00, 32'h0000_0041);
        cmp_reg({28'h0, mode[0]}, 32'h0000_0009);
        ev(0, 3'h1, 1'b0, 1'b1);
        cmp_pin(0, 0, 3'h3);
        bus(1'b1, 8'h00, 32'h0000_0043);
        ev(0, 3'h1, 1'b0, 1'b1);
        cmp_pin(0, 0, 3'h7);
        bus(1'b1, 8'h00, 32'h0000_0051);
        cmp_pin(0, 1, 3'h0, 3'h3);
        bus(1'b1, 8'h00, 32'h0000_0081);
        ev(0, 3'h1, 1'b0, 1'b1);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h7);
        ev(0, 3'h0, 1'b0, 1'b0, 3'h0, 3'h1);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h0, 1'b0, 1'b0, 3'h1);
        cmp_pin(0, 0, 3'h7);
        bus(1'b1, 8'h00, 32'h0000_00C1);
        ev(0, 3'h0, 1'b0, 1'b0, 3'h1);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h0, 1'b0, 1'b0, 3'h0, 3'h1);
        cmp_pin(0, 0, 3'h7);
        ev(0, 3'h1, 1'b0, 1'b0);
        cmp_pin(0, 0, 3'h3);
        ev(0, 3'h1, 1'b0, 1'b1);
        cmp_pin(0, 0, 3'h7);
        // Second timer runs on its own settings
        bus(1'b1, 8'h08, 32'h0000_00C0);
        ev(1, 3'h1, 1'b0, 1'b0);
        cmp_pin(1, 0, 3'h7);
        rd(8'h08, 32'h0000_00C0);
        bus(1'b0, 8'h10, 32'h0000_0000);
        cmp_reg(q & 32'h0000_0011, 32'h0000_0011);
        cmp_reg({28'h0, mode[1]}, 32'h0000_0000);
        // Upper mode bits of the second timer
        bus(1'b1, 8'h0C, 32'h0000_0018);
        rd(8'h0C, 32'h0000_0018);
        cmp_reg({28'h0, mode[1]}, 32'h0000_000C);
        complete_run();
    end

    // Whole sequence needs a few hundred cycles; this is a backstop, since the bus task ends a hung wait after 50 cycles
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

endmodule : test_tcoc_top

`default_nettype wire
